// >>> rtl/pwm_pkg.sv
// Package with register map, field layouts and reset values of the timer based PWM unit.
package pwm_pkg;

  localparam int unsigned NUM_MATCH = 7;
  localparam int unsigned NUM_OUT = 6;

  // Register word offsets (byte address = 4 * index).
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_PRESCALE = 6'h01;
  localparam logic [5:0] ADDR_PRESCALE_CNT = 6'h02;
  localparam logic [5:0] ADDR_COUNTER = 6'h03;
  localparam logic [5:0] ADDR_MATCH_CTRL = 6'h04;
  localparam logic [5:0] ADDR_PWM_CTRL = 6'h05;
  localparam logic [5:0] ADDR_LATCH = 6'h06;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h07;
  localparam logic [5:0] ADDR_IRQ_CLEAR = 6'h08;
  localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h09;
  localparam logic [5:0] ADDR_MATCH_BASE = 6'h10;

  // Control register bits.
  localparam int unsigned CTRL_COUNT_EN = 0;
  localparam int unsigned CTRL_RESET = 1;
  localparam int unsigned CTRL_PWM_EN = 3;

  // Match control: three bits per match register.
  localparam int unsigned MC_IRQ = 0;
  localparam int unsigned MC_RESET = 1;
  localparam int unsigned MC_STOP = 2;

  // Output control: select bits 2..6 choose double edge, enable bits 9..14.
  localparam int unsigned PC_SEL_LSB = 0;
  localparam int unsigned PC_ENA_LSB = 8;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [5:0] addr;
    logic read;
    logic write;
    logic [31:0] wdata;
  } bus_req_t;

endpackage : pwm_pkg

// >>> rtl/pwm_edge_out.sv
// One PWM output channel: single or double edge set/reset flip-flop.
`timescale 1ns/1ps
`default_nettype none

module pwm_edge_out (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // Control
  input wire logic enable,
  input wire logic double_edge,
  // Match events
  input wire logic period_hit,
  input wire logic rise_hit,
  input wire logic fall_hit,
  // Output
  output logic pwm
);

  logic next_pwm;

  always_comb begin
    next_pwm = pwm;
    if (!enable) begin
      next_pwm = 1'b0;
    end else if (double_edge) begin
      // A fall that coincides with a rise wins, keeping the output low.
      if (fall_hit) begin
        next_pwm = 1'b0;
      end else if (rise_hit) begin
        next_pwm = 1'b1;
      end
    end else begin
      if (fall_hit) begin
        next_pwm = 1'b0;
      end else if (period_hit) begin
        next_pwm = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwm <= 1'b0;
    end else if (clk_en) begin
      pwm <= next_pwm;
    end
  end

endmodule : pwm_edge_out

`default_nettype wire

// >>> rtl/pwm_unit.sv
// Timer based PWM unit with Avalon-MM register slave and match interrupts.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Prescaler of 32 bits counts clocks and advances a 32-bit counter.
// - Seven match registers drive six single or five double edge outputs.
// - In PWM mode the period match resets the counter and starts a new cycle.
// - Single edge output uses one own match register for its falling edge.
// - Single edge outputs rise at period match unless held constantly low.
// - Double edge output uses two matches, one rising, one falling edge.
// - Rising match before falling gives positive pulse, reversed gives negative.
// - Period and width take any count; all outputs share one rate.
// - Each match may keep counting, stop, or reset, optionally interrupting.
// - In PWM mode new match values apply only after software releases them; plain timer mode uses them at once.
// - With PWM mode off the block is a plain timer without outputs.
module pwm_unit (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Outputs
  output logic [pwm_pkg::NUM_OUT-1:0] pwm_out,
  output logic irq
);

  localparam int unsigned NM = pwm_pkg::NUM_MATCH;

  pwm_pkg::bus_req_t req;
  assign req = '{addr: address, read: read, write: write, wdata: writedata};

  logic [31:0] ctrl;
  logic [31:0] prescale;
  logic [31:0] pre_cnt;
  logic [31:0] counter;
  logic [20:0] match_ctrl;
  logic [15:0] pwm_ctrl;
  logic [NM-1:0] latch_req;
  logic [NM-1:0] irq_status;
  logic [NM-1:0] irq_enable;
  logic [31:0] shadow [NM];
  logic [31:0] active [NM];
  // Busy marks the answer cycle so a request still held there is not taken twice.
  logic busy;

  logic [31:0] next_ctrl;
  logic [31:0] next_prescale;
  logic [31:0] next_pre_cnt;
  logic [31:0] next_counter;
  logic [20:0] next_match_ctrl;
  logic [15:0] next_pwm_ctrl;
  logic [NM-1:0] next_latch_req;
  logic [NM-1:0] next_irq_status;
  logic [NM-1:0] next_irq_enable;
  logic [31:0] next_shadow [NM];
  logic [31:0] next_active [NM];
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic next_busy;
  logic next_irq;

  logic [NM-1:0] hit;
  logic tick;
  logic running;
  logic pwm_mode;
  logic period_hit;
  logic wr_now;
  logic [NM-1:0] load_now;
  logic [NM-1:0] reset_hit;
  logic [NM-1:0] stop_hit;
  logic [NM-1:0] irq_hit;

  function automatic logic is_match_addr(input logic [5:0] a);
    return (a >= pwm_pkg::ADDR_MATCH_BASE) &&
           (a < pwm_pkg::ADDR_MATCH_BASE + 6'(NM));
  endfunction : is_match_addr

  function automatic logic [2:0] match_index(input logic [5:0] a);
    return 3'(a - pwm_pkg::ADDR_MATCH_BASE);
  endfunction : match_index

  // Gathers one action bit of every match out of the packed match control word.
  function automatic logic [NM-1:0] action_mask(input logic [20:0] mc, input int unsigned pos);
    logic [NM-1:0] m;
    m = '0;
    for (int i = 0; i < NM; i++) begin
      m[i] = mc[3*i+pos];
    end
    return m;
  endfunction : action_mask

  // Decodes a completing bus write to one register index.
  function automatic logic write_to(input logic go, input logic [5:0] a, input logic [5:0] target);
    return go && (a == target);
  endfunction : write_to

  function automatic logic [31:0] status_word(input logic [NM-1:0] v);
    return 32'(v);
  endfunction : status_word

  assign running = ctrl[pwm_pkg::CTRL_COUNT_EN] && !ctrl[pwm_pkg::CTRL_RESET];
  assign pwm_mode = ctrl[pwm_pkg::CTRL_PWM_EN];
  assign tick = running && (pre_cnt == prescale);

  // A match fires on the counter tick that reaches its active value.
  genvar gi;
  generate
    for (gi = 0; gi < NM; gi++) begin : g_hit
      assign hit[gi] = tick && (counter == active[gi]);
    end
  endgenerate
  assign period_hit = hit[0];

  // Writes land on the edge at which the master sees waitrequest low, never on the accepting edge.
  assign wr_now = req.write && !waitrequest;

  // A release waits for the period match so a cycle never mixes old and new edge positions.
  assign load_now = pwm_mode ? (latch_req & {NM{period_hit}}) : '0;

  // Per match actions, each gated by its own control bit.
  assign reset_hit = hit & action_mask(match_ctrl, pwm_pkg::MC_RESET);
  assign stop_hit = hit & action_mask(match_ctrl, pwm_pkg::MC_STOP);
  assign irq_hit = hit & action_mask(match_ctrl, pwm_pkg::MC_IRQ);

  // Counter, prescaler and match actions.
  always_comb begin
    next_pre_cnt = pre_cnt;
    next_counter = counter;
    next_ctrl = ctrl;
    if (ctrl[pwm_pkg::CTRL_RESET]) begin
      next_pre_cnt = pwm_pkg::RESET_WORD;
      next_counter = pwm_pkg::RESET_WORD;
    end else if (running) begin
      if (tick) begin
        next_pre_cnt = pwm_pkg::RESET_WORD;
        next_counter = counter + 32'h0000_0001;
        if (|reset_hit) begin
          next_counter = pwm_pkg::RESET_WORD;
        end
        // In PWM mode the period match restarts the cycle even without its reset bit, unless a stop fires on the same tick.
        if (pwm_mode && period_hit) begin
          next_counter = pwm_pkg::RESET_WORD;
        end
        // A stop freezes the counter on the matched value so software can read it back.
        if (|stop_hit) begin
          next_counter = counter;
          next_ctrl[pwm_pkg::CTRL_COUNT_EN] = 1'b0;
        end
      end else begin
        next_pre_cnt = pre_cnt + 32'h0000_0001;
      end
    end
    // Software writes to the counting registers win over counting in the same cycle.
    if (write_to(wr_now, req.addr, pwm_pkg::ADDR_CTRL)) begin
      next_ctrl = req.wdata;
    end
    if (write_to(wr_now, req.addr, pwm_pkg::ADDR_COUNTER)) begin
      next_counter = req.wdata;
    end
    if (write_to(wr_now, req.addr, pwm_pkg::ADDR_PRESCALE_CNT)) begin
      next_pre_cnt = req.wdata;
    end
  end

  // Registers, double buffering, interrupts and bus answer.
  always_comb begin
    next_prescale = prescale;
    next_match_ctrl = match_ctrl;
    next_pwm_ctrl = pwm_ctrl;
    next_latch_req = latch_req;
    next_irq_status = irq_status;
    next_irq_enable = irq_enable;
    next_readdata = readdata;
    next_waitrequest = 1'b1;
    next_busy = 1'b0;
    for (int i = 0; i < NM; i++) begin
      next_shadow[i] = shadow[i];
      next_active[i] = active[i];
    end
    // Plain timer mode uses the written values at once; PWM mode waits for a release.
    for (int i = 0; i < NM; i++) begin
      if (!pwm_mode) begin
        next_active[i] = shadow[i];
      end else if (load_now[i]) begin
        next_active[i] = shadow[i];
        next_latch_req[i] = 1'b0;
      end
    end
    if ((req.read || req.write) && !busy) begin
      next_busy = 1'b1;
      next_waitrequest = 1'b0;
      next_readdata = pwm_pkg::RESET_WORD;
      if (req.read) begin
        if (is_match_addr(req.addr)) begin
          next_readdata = shadow[match_index(req.addr)];
        end
        case (req.addr)
          pwm_pkg::ADDR_CTRL: next_readdata = ctrl;
          pwm_pkg::ADDR_PRESCALE: next_readdata = prescale;
          pwm_pkg::ADDR_PRESCALE_CNT: next_readdata = pre_cnt;
          pwm_pkg::ADDR_COUNTER: next_readdata = counter;
          pwm_pkg::ADDR_MATCH_CTRL: next_readdata = {11'h000, match_ctrl};
          pwm_pkg::ADDR_PWM_CTRL: next_readdata = {16'h0000, pwm_ctrl};
          pwm_pkg::ADDR_LATCH: next_readdata = status_word(latch_req);
          pwm_pkg::ADDR_IRQ_STATUS: next_readdata = status_word(irq_status);
          pwm_pkg::ADDR_IRQ_ENABLE: next_readdata = status_word(irq_enable);
          default: next_readdata = next_readdata;
        endcase
      end
    end
    // Register writes land on the completing edge, while waitrequest stands low.
    if (wr_now) begin
      if (is_match_addr(req.addr)) begin
        next_shadow[match_index(req.addr)] = req.wdata;
      end
      case (req.addr)
        pwm_pkg::ADDR_PRESCALE: next_prescale = req.wdata;
        pwm_pkg::ADDR_MATCH_CTRL: next_match_ctrl = req.wdata[20:0];
        pwm_pkg::ADDR_PWM_CTRL: next_pwm_ctrl = req.wdata[15:0];
        pwm_pkg::ADDR_LATCH: next_latch_req = next_latch_req | req.wdata[NM-1:0];
        pwm_pkg::ADDR_IRQ_CLEAR: next_irq_status = irq_status & ~req.wdata[NM-1:0];
        pwm_pkg::ADDR_IRQ_ENABLE: next_irq_enable = req.wdata[NM-1:0];
        default: next_irq_enable = next_irq_enable;
      endcase
    end
    // Sets come after the clear so an event in the clearing cycle survives.
    for (int i = 0; i < NM; i++) begin
      if (irq_hit[i]) begin
        next_irq_status[i] = 1'b1;
      end
    end
    next_irq = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl <= pwm_pkg::RESET_WORD;
      prescale <= pwm_pkg::RESET_WORD;
      pre_cnt <= pwm_pkg::RESET_WORD;
      counter <= pwm_pkg::RESET_WORD;
      match_ctrl <= '0;
      pwm_ctrl <= '0;
      latch_req <= '0;
      irq_status <= '0;
      irq_enable <= '0;
      readdata <= pwm_pkg::RESET_WORD;
      waitrequest <= 1'b1;
      busy <= 1'b0;
      irq <= 1'b0;
      for (int i = 0; i < NM; i++) begin
        shadow[i] <= pwm_pkg::RESET_WORD;
        active[i] <= pwm_pkg::RESET_WORD;
      end
    end else if (clk_en) begin
      ctrl <= next_ctrl;
      prescale <= next_prescale;
      pre_cnt <= next_pre_cnt;
      counter <= next_counter;
      match_ctrl <= next_match_ctrl;
      pwm_ctrl <= next_pwm_ctrl;
      latch_req <= next_latch_req;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
      busy <= next_busy;
      irq <= next_irq;
      for (int i = 0; i < NM; i++) begin
        shadow[i] <= next_shadow[i];
        active[i] <= next_active[i];
      end
    end
  end

  // Output n uses match n as its falling edge; double edge uses match n-1 to rise.
  generate
    for (gi = 1; gi <= pwm_pkg::NUM_OUT; gi++) begin : g_out
      pwm_edge_out u_edge (
        .clock(clock),
        .nrst(nrst),
        .clk_en(clk_en),
        .enable(pwm_mode && pwm_ctrl[pwm_pkg::PC_ENA_LSB+gi]),
        .double_edge((gi > 1) && pwm_ctrl[pwm_pkg::PC_SEL_LSB+gi]),
        .period_hit(period_hit),
        .rise_hit(hit[gi-1]),
        .fall_hit(hit[gi]),
        .pwm(pwm_out[gi-1])
      );
    end
  endgenerate

endmodule : pwm_unit

`default_nettype wire

// >>> sim/pwm_unit_sva.sv
// Port level assertion checker for the PWM unit.
`timescale 1ns/1ps
`default_nettype none

module pwm_unit_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Outputs
  input wire logic [pwm_pkg::NUM_OUT-1:0] pwm_out,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [31:0] ctrl_q, pcr_q, ien_q, next_ctrl, next_pcr, next_ien;
  logic wr_done;
  assign wr_done = write && !waitrequest;
  // Shadows of what software wrote, so outputs can be judged against them.
  always_comb begin
    next_ctrl = ctrl_q;
    next_pcr = pcr_q;
    next_ien = ien_q;
    if (wr_done && address == pwm_pkg::ADDR_CTRL) next_ctrl = writedata;
    if (wr_done && address == pwm_pkg::ADDR_PWM_CTRL) next_pcr = writedata;
    if (wr_done && address == pwm_pkg::ADDR_IRQ_ENABLE) next_ien = writedata;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= '0;
      pcr_q <= '0;
      ien_q <= '0;
    end else begin
      ctrl_q <= next_ctrl;
      pcr_q <= next_pcr;
      ien_q <= next_ien;
    end
  end
  sequence s_req;
    clk_en && (read || write) && waitrequest;
  endsequence
  sequence s_ans;
    !waitrequest ##1 waitrequest;
  endsequence
  chk_bus_answer: assert property (clk_en && $rose(read || write) |-> ##1 s_ans)
    else $error("bus answer not one cycle after request");
  chk_bus_bound: assert property (s_req |-> ##[0:2] !waitrequest)
    else $error("bus request left waiting");
  chk_no_spont: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without request");
  chk_unmapped_zero: assert property (read && !waitrequest && address > 6'h16 |-> readdata == '0)
    else $error("unmapped read not zero");
  chk_off_low: assert property (
    !ctrl_q[pwm_pkg::CTRL_PWM_EN] && !$past(ctrl_q[pwm_pkg::CTRL_PWM_EN]) |-> pwm_out == '0)
    else $error("output active with PWM mode off");
  chk_dis_low: assert property ((pwm_out & ~(pcr_q[14:9] | $past(pcr_q[14:9]))) == '0)
    else $error("disabled output active");
  chk_irq_mask: assert property (ien_q == '0 && $past(ien_q) == '0 |-> !irq)
    else $error("irq with all sources masked");
  for (genvar i = 1; i < pwm_pkg::NUM_OUT; i++) begin : g_rise
    chk_common_rise: assert property (
      $rose(pwm_out[i]) && pcr_q[9] && pcr_q[9+i] && !pcr_q[i+1] && $stable(pcr_q)
      && ctrl_q[pwm_pkg::CTRL_PWM_EN] |-> $rose(pwm_out[0]))
      else $error("single edge outputs rise apart");
  end
endmodule : pwm_unit_sva

bind pwm_unit pwm_unit_sva u_pwm_unit_sva (.clock(clock), .nrst(nrst), .clk_en(clk_en),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .pwm_out(pwm_out), .irq(irq));

`default_nettype wire

// >>> sim/pwm_load.sv
// Load model on the PWM pins that measures period and high time of each output.
`timescale 1ns/1ps
`default_nettype none

module pwm_load (
  // Clock
  input wire logic clock,
  // Pins
  input wire logic [pwm_pkg::NUM_OUT-1:0] pwm,
  // Measurements in clock cycles
  output logic [15:0] hi_len [pwm_pkg::NUM_OUT],
  output logic [15:0] per_len [pwm_pkg::NUM_OUT]
);
  logic [15:0] cnt [pwm_pkg::NUM_OUT];
  logic [15:0] hc [pwm_pkg::NUM_OUT];
  logic [pwm_pkg::NUM_OUT-1:0] prev = '0;
  always @(posedge clock) begin
    for (int i = 0; i < pwm_pkg::NUM_OUT; i++) begin
      cnt[i] <= (pwm[i] && !prev[i]) ? 16'h0001 : cnt[i] + 16'h0001;
      if (pwm[i] && !prev[i]) per_len[i] <= cnt[i];
      hc[i] <= pwm[i] ? (prev[i] ? hc[i] + 16'h0001 : 16'h0001) : hc[i];
      if (!pwm[i] && prev[i]) hi_len[i] <= hc[i];
    end
    prev <= pwm;
  end
endmodule : pwm_load

`default_nettype wire

// >>> sim/testbench.sv
// Self-checking testbench for the PWM unit.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata, q;
  logic waitrequest, irq;
  logic [pwm_pkg::NUM_OUT-1:0] pwm_out;
  logic [15:0] hi_len [pwm_pkg::NUM_OUT];
  logic [15:0] per_len [pwm_pkg::NUM_OUT];
  int fails = 0;
  int checks_done = 0;
  int p, s, r, f, w, seed;
  pwm_unit u_pwm_unit (.clock(clock), .nrst(nrst), .clk_en(clk_en), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pwm_out(pwm_out), .irq(irq));
  pwm_load u_pwm_load (.clock(clock), .pwm(pwm_out), .hi_len(hi_len), .per_len(per_len));
  initial begin
    forever #25 clock = ~clock;
  end
  task automatic conclude();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // The request stands until the rising edge that samples waitrequest low; data is taken there.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      fails++;
      conclude();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  function automatic int exp_hi(input int p, input int r, input int f);
    return (r < f) ? f - r : p + 1 - r + f;
  endfunction : exp_hi
  initial begin
    seed = $urandom(32'h0CE42AFB);
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    check("pwm_out", 32'(pwm_out), 32'h00000000);
    check("irq", 32'(irq), 32'h00000000);
    bus(1'b0, pwm_pkg::ADDR_CTRL, 32'h00000000);
    check("ctrl", q, pwm_pkg::RESET_WORD);
    bus(1'b0, 6'h3F, 32'h00000000);
    check("unmapped", q, 32'h00000000);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      p = 8 + $urandom_range(12);
      s = $urandom_range(2);
      r = (k == 1) ? p - 1 : 1 + $urandom_range(p - 2);
      f = (k == 0) ? p - 1 : 1 + $urandom_range(p - 2);
      if (f == r) f = (r % (p - 1)) + 1;
      w = 1 + $urandom_range(p - 2);
      bus(1'b1, pwm_pkg::ADDR_CTRL, 32'h00000002);
      bus(1'b1, pwm_pkg::ADDR_PRESCALE, 32'(s));
      bus(1'b1, pwm_pkg::ADDR_MATCH_BASE, 32'(p));
      bus(1'b1, pwm_pkg::ADDR_MATCH_BASE + 6'h01, 32'(r));
      bus(1'b1, pwm_pkg::ADDR_MATCH_BASE + 6'h02, 32'(f));
      bus(1'b1, pwm_pkg::ADDR_MATCH_BASE + 6'h03, 32'(w));
      bus(1'b1, pwm_pkg::ADDR_PWM_CTRL, 32'h00000E04);
      bus(1'b1, pwm_pkg::ADDR_LATCH, 32'h0000000F);
      bus(1'b1, pwm_pkg::ADDR_CTRL, 32'h00000009);
      idle(3 * (p + 1) * (s + 1) + 4);
      // A single edge output stays high from the period match through the tick of its own match.
      check("hi1", 32'(hi_len[0]), 32'((r + 1) * (s + 1)));
      check("per1", 32'(per_len[0]), 32'((p + 1) * (s + 1)));
      check("hi2", 32'(hi_len[1]), 32'(exp_hi(p, r, f) * (s + 1)));
      check("per2", 32'(per_len[1]), 32'((p + 1) * (s + 1)));
      check("hi3", 32'(hi_len[2]), 32'((w + 1) * (s + 1)));
      $display("test pwm %0d done", k);
    end
    bus(1'b1, pwm_pkg::ADDR_MATCH_BASE + 6'h01, 32'((r % (p - 1)) + 1));
    idle(3 * (p + 1) * (s + 1));
    check("held", 32'(hi_len[0]), 32'((r + 1) * (s + 1)));
    bus(1'b1, pwm_pkg::ADDR_LATCH, 32'h00000002);
    idle(3 * (p + 1) * (s + 1));
    check("released", 32'(hi_len[0]), 32'(((r % (p - 1)) + 2) * (s + 1)));
    $display("test release done");
    bus(1'b1, pwm_pkg::ADDR_MATCH_CTRL, 32'h00000001);
    bus(1'b1, pwm_pkg::ADDR_IRQ_ENABLE, 32'h00000001);
    for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge clock);
    check("irq set", 32'(irq), 32'h00000001);
    if (irq !== 1'b1) begin
      conclude();
    end
    bus(1'b1, pwm_pkg::ADDR_CTRL, 32'h00000000);
    bus(1'b1, pwm_pkg::ADDR_IRQ_ENABLE, 32'h00000000);
    idle(2);
    check("irq masked", 32'(irq), 32'h00000000);
    bus(1'b0, pwm_pkg::ADDR_IRQ_STATUS, 32'h00000000);
    check("status", q & 32'h00000001, 32'h00000001);
    bus(1'b1, pwm_pkg::ADDR_IRQ_ENABLE, 32'h00000001);
    idle(2);
    check("irq unmasked", 32'(irq), 32'h00000001);
    bus(1'b1, pwm_pkg::ADDR_IRQ_CLEAR, 32'h00000001);
    idle(2);
    check("irq cleared", 32'(irq), 32'h00000000);
    bus(1'b0, pwm_pkg::ADDR_IRQ_STATUS, 32'h00000000);
    check("status clr", q & 32'h00000001, 32'h00000000);
    $display("test irq done");
    bus(1'b1, pwm_pkg::ADDR_CTRL, 32'h00000002);
    bus(1'b1, pwm_pkg::ADDR_MATCH_CTRL, 32'h00000800);
    bus(1'b1, pwm_pkg::ADDR_CTRL, 32'h00000001);
    idle((w + 2) * (s + 1) + 4);
    bus(1'b0, pwm_pkg::ADDR_COUNTER, 32'h00000000);
    check("stopped", q, 32'(w));
    check("timer out", 32'(pwm_out), 32'h00000000);
    $display("test timer done");
    conclude();
  end
endmodule : testbench

`default_nettype wire
